// >>> rtl/tcd_pkg.sv
package tcd_pkg;

  // ---------------------------------------------------------------
  // channel map
  // ---------------------------------------------------------------
  localparam int         NCH        = 2;
  localparam logic [2:0] BLOCK_TAG  = 3'h6;   // I_ADDR[7:5] of both channel banks
  localparam logic [3:0] OFF_SRC_LO = 4'h0;
  localparam logic [3:0] OFF_SRC_HI = 4'h2;
  localparam logic [3:0] OFF_DST_LO = 4'h4;
  localparam logic [3:0] OFF_DST_HI = 4'h6;
  localparam logic [3:0] OFF_CNT    = 4'h8;
  localparam logic [3:0] OFF_CTL    = 4'ha;
  localparam int         CH_SEL_BIT = 4;      // I_ADDR[4]: 0 -> c0h bank, 1 -> d0h bank

  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int CTL_DST_MEM  = 15;
  localparam int CTL_DST_DOWN = 14;
  localparam int CTL_DST_UP   = 13;
  localparam int CTL_SRC_MEM  = 12;
  localparam int CTL_SRC_DOWN = 11;
  localparam int CTL_SRC_UP   = 10;
  localparam int CTL_TERM_EN  = 9;
  localparam int CTL_INT      = 8;
  localparam int CTL_SYNC_HI  = 7;
  localparam int CTL_SYNC_LO  = 6;
  localparam int CTL_PRIO     = 5;
  localparam int CTL_TMR      = 4;
  localparam int CTL_GUARD    = 2;
  localparam int CTL_RUN      = 1;
  localparam int CTL_WORD     = 0;

  localparam logic [15:0] CTL_STORE_MASK = 16'hfff1;
  localparam logic [1:0]  SYNC_NONE      = 2'h0;
  localparam logic [1:0]  SYNC_SRC       = 2'h1;
  localparam logic [1:0]  SYNC_DST       = 2'h2;

  // ---------------------------------------------------------------
  // reset values, timing counts (in processor clocks) and pointer steps
  // ---------------------------------------------------------------
  localparam logic [15:0] CTL_RESET     = 16'h0000;
  localparam logic [19:0] PTR_RESET     = 20'h00000;
  localparam logic [15:0] CNT_RESET     = 16'h0000;
  localparam int          PIN_DELAY_CYC = 4;
  localparam logic [1:0]  SRC_GAP_CYC   = 2'h3;
  localparam logic [1:0]  DST_IDLE_CYC  = 2'h2;
  localparam logic [19:0] STEP_BYTE     = 20'h00001;
  localparam logic [19:0] STEP_WORD     = 20'h00002;

  typedef enum logic [1:0] {S_IDLE, S_READ, S_WRITE, S_GAP} tcd_state_e;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        mem_space;
    logic        word;
    logic [19:0] addr;
    logic [15:0] data;
  } tcd_bus_s;

endpackage

// >>> rtl/tcd_dma_unit.sv
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps

// Contract
// - two channels; pin, serial or timer requests
// - any space pair, byte/word, read then write
// - read and write cycles kept back to back
// - count drops by one per transfer
// - pointers drive all twenty address lines
// - bits 15/12 pick destination/source space
// - destination pointer down/up/hold by 14/13
// - source pointer down/up/hold by 11/10
// - bit 0 steps two for word, else one
// - zero count stops unsynchronized; synchronized if bit 9
// - interrupt at count end when 8 and 9
// - bits 7-6 choose synchronization, 11 reserved
// - bit 5 channel wins simultaneous requests
// - bit 4 gates timer overflow request
// - bit 1 starts or stops the channel
// - pin request acts four clocks later
// - source-synchronized gives three clocks to withdraw
// - destination-synchronized adds two idle states
// - halt flag from nmi stops, iret resumes
module tcd_dma_unit (
  input  wire logic             I_CLK,
  input  wire logic             I_RST_N,
  input  wire logic [7:0]       I_ADDR,
  input  wire logic [15:0]      I_WDATA,
  input  wire logic             I_WR,
  input  wire logic             I_RD,
  output logic      [15:0]      O_RDATA,
  input  wire logic [1:0]       I_REQ_PIN,
  input  wire logic [1:0]       I_SERIAL_SEL,
  input  wire logic [1:0]       I_SERIAL_REQ,
  input  wire logic             I_TIMER_OVF,
  input  wire logic             I_NMI,
  input  wire logic             I_IRET,
  output tcd_pkg::tcd_bus_s     O_BUS,
  output logic                  O_BUS_LOCK,
  input  wire logic             I_BUS_DONE,
  input  wire logic [15:0]      I_BUS_RDATA,
  output logic      [1:0]       O_IRQ,
  output logic                  O_HALTED
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [1:0][19:0]     src;
  logic [1:0][19:0]     dst;
  logic [1:0][15:0]     cnt;
  logic [1:0][15:0]     ctl;
  logic [1:0][19:0]     next_src;
  logic [1:0][19:0]     next_dst;
  logic [1:0][15:0]     next_cnt;
  logic [1:0][15:0]     next_ctl;
  tcd_pkg::tcd_state_e  state;
  tcd_pkg::tcd_state_e  next_state;
  tcd_pkg::tcd_bus_s    bus;
  tcd_pkg::tcd_bus_s    next_bus;
  logic                 cur;
  logic                 next_cur;
  logic [1:0]           gap;
  logic [1:0]           next_gap;
  logic                 halt;
  logic                 next_halt;
  logic [1:0]           irq;
  logic [1:0]           next_irq;
  logic [15:0]          rdata;
  logic [15:0]          next_rdata;
  logic [1:0]           want;
  logic [1:0]           take;

  // ---------------------------------------------------------------
  // per-channel request qualification
  // ---------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < tcd_pkg::NCH; ch++) begin : g_req
      logic [tcd_pkg::PIN_DELAY_CYC-1:0] pin_pipe;
      logic [tcd_pkg::PIN_DELAY_CYC-1:0] next_pin_pipe;
      logic                              tmr_pend;
      logic                              next_tmr_pend;
      logic                              ext;
      logic [1:0]                        sync;

      always_comb begin
        // serial port owning the channel masks the pin
        next_pin_pipe = {pin_pipe[tcd_pkg::PIN_DELAY_CYC-2:0],
                         I_REQ_PIN[ch] & ~I_SERIAL_SEL[ch]};
        // overflow that lands on the taking cycle is kept
        next_tmr_pend = (I_TIMER_OVF & ctl[ch][tcd_pkg::CTL_TMR])
                      | (tmr_pend & ~take[ch]);
        ext  = I_SERIAL_SEL[ch] ? I_SERIAL_REQ[ch]
                                : pin_pipe[tcd_pkg::PIN_DELAY_CYC-1];
        sync = ctl[ch][tcd_pkg::CTL_SYNC_HI:tcd_pkg::CTL_SYNC_LO];
        unique case (sync)
          tcd_pkg::SYNC_NONE: want[ch] = ctl[ch][tcd_pkg::CTL_RUN];
          tcd_pkg::SYNC_SRC,
          tcd_pkg::SYNC_DST:  want[ch] = ctl[ch][tcd_pkg::CTL_RUN] & (ext | tmr_pend);
          default:            want[ch] = 1'b0;
        endcase
      end

      always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
          pin_pipe <= '0;
          tmr_pend <= 1'b0;
        end else begin
          pin_pipe <= next_pin_pipe;
          tmr_pend <= next_tmr_pend;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [19:0] step_ptr(input logic [19:0] p, input logic up,
                                           input logic down, input logic word);
    logic [19:0] inc;
    inc = word ? tcd_pkg::STEP_WORD : tcd_pkg::STEP_BYTE;
    if (up & ~down) begin
      step_ptr = p + inc;
    end else if (down & ~up) begin
      step_ptr = p - inc;
    end else begin
      step_ptr = p;
    end
  endfunction

  // ---------------------------------------------------------------
  // transfer engine and register file
  // ---------------------------------------------------------------
  always_comb begin
    logic        pick;
    logic        hit;
    logic        wch;
    logic [15:0] new_cnt;
    logic        term;
    logic [1:0]  sync;
    logic        run_keep;
    pick       = 1'b0;
    hit        = 1'b0;
    wch        = 1'b0;
    new_cnt    = '0;
    term       = 1'b0;
    sync       = '0;
    run_keep   = 1'b0;
    next_src   = src;
    next_dst   = dst;
    next_cnt   = cnt;
    next_ctl   = ctl;
    next_state = state;
    next_bus   = bus;
    next_cur   = cur;
    next_gap   = gap;
    next_irq   = '0;
    next_rdata = '0;
    take       = '0;
    next_halt  = I_NMI | (halt & ~I_IRET);

    unique case (state)
      tcd_pkg::S_IDLE: begin
        // halt only blocks new grants; a started pair always completes
        if (!halt && (want != 2'b00)) begin
          pick = want[1] & (~want[0] | (ctl[1][tcd_pkg::CTL_PRIO]
                                       & ~ctl[0][tcd_pkg::CTL_PRIO]));
          take[pick]         = 1'b1;
          next_cur           = pick;
          next_bus.valid     = 1'b1;
          next_bus.write     = 1'b0;
          next_bus.addr      = src[pick];
          next_bus.mem_space = ctl[pick][tcd_pkg::CTL_SRC_MEM];
          next_bus.word      = ctl[pick][tcd_pkg::CTL_WORD];
          next_state         = tcd_pkg::S_READ;
        end
      end
      tcd_pkg::S_READ: begin
        if (I_BUS_DONE) begin
          next_bus.write     = 1'b1;
          next_bus.data      = I_BUS_RDATA;
          next_bus.addr      = dst[cur];
          next_bus.mem_space = ctl[cur][tcd_pkg::CTL_DST_MEM];
          next_state         = tcd_pkg::S_WRITE;
        end
      end
      tcd_pkg::S_WRITE: begin
        if (I_BUS_DONE) begin
          sync           = ctl[cur][tcd_pkg::CTL_SYNC_HI:tcd_pkg::CTL_SYNC_LO];
          next_bus.valid = 1'b0;
          next_bus.write = 1'b0;
          next_src[cur]  = step_ptr(src[cur], ctl[cur][tcd_pkg::CTL_SRC_UP],
                                    ctl[cur][tcd_pkg::CTL_SRC_DOWN],
                                    ctl[cur][tcd_pkg::CTL_WORD]);
          next_dst[cur]  = step_ptr(dst[cur], ctl[cur][tcd_pkg::CTL_DST_UP],
                                    ctl[cur][tcd_pkg::CTL_DST_DOWN],
                                    ctl[cur][tcd_pkg::CTL_WORD]);
          new_cnt        = cnt[cur] - 16'h0001;
          next_cnt[cur]  = new_cnt;
          term = (new_cnt == 16'h0000)
               & ((sync == tcd_pkg::SYNC_NONE) | ctl[cur][tcd_pkg::CTL_TERM_EN]);
          if (term) begin
            next_ctl[cur][tcd_pkg::CTL_RUN] = 1'b0;
            next_irq[cur] = ctl[cur][tcd_pkg::CTL_INT] & ctl[cur][tcd_pkg::CTL_TERM_EN];
          end
          if (sync == tcd_pkg::SYNC_DST) begin
            next_gap   = tcd_pkg::DST_IDLE_CYC;
            next_state = tcd_pkg::S_GAP;
          end else if (sync == tcd_pkg::SYNC_SRC) begin
            next_gap   = tcd_pkg::SRC_GAP_CYC;
            next_state = tcd_pkg::S_GAP;
          end else begin
            next_state = tcd_pkg::S_IDLE;
          end
        end
      end
      tcd_pkg::S_GAP: begin
        next_gap = gap - 2'h1;
        if (gap == 2'h1) begin
          next_state = tcd_pkg::S_IDLE;
        end
      end
    endcase

    // software access; a write here overrides the hardware update, except the run bit of a control write with the guard bit clear
    hit = (I_ADDR[7:5] == tcd_pkg::BLOCK_TAG);
    wch = I_ADDR[tcd_pkg::CH_SEL_BIT];
    if (I_WR && hit) begin
      unique case (I_ADDR[3:0])
        tcd_pkg::OFF_SRC_LO: next_src[wch][15:0]  = I_WDATA;
        tcd_pkg::OFF_SRC_HI: next_src[wch][19:16] = I_WDATA[3:0];
        tcd_pkg::OFF_DST_LO: next_dst[wch][15:0]  = I_WDATA;
        tcd_pkg::OFF_DST_HI: next_dst[wch][19:16] = I_WDATA[3:0];
        tcd_pkg::OFF_CNT:    next_cnt[wch]        = I_WDATA;
        tcd_pkg::OFF_CTL: begin
          // guard clear keeps the run bit as hardware leaves it this cycle
          run_keep      = next_ctl[wch][tcd_pkg::CTL_RUN];
          next_ctl[wch] = I_WDATA & tcd_pkg::CTL_STORE_MASK;
          // guard set: the written run bit beats a same-cycle hardware stop
          next_ctl[wch][tcd_pkg::CTL_RUN] = I_WDATA[tcd_pkg::CTL_GUARD]
                                          ? I_WDATA[tcd_pkg::CTL_RUN]
                                          : run_keep;
        end
        default: ;
      endcase
    end
    if (I_RD && hit) begin
      unique case (I_ADDR[3:0])
        tcd_pkg::OFF_SRC_LO: next_rdata = src[wch][15:0];
        tcd_pkg::OFF_SRC_HI: next_rdata = {12'h000, src[wch][19:16]};
        tcd_pkg::OFF_DST_LO: next_rdata = dst[wch][15:0];
        tcd_pkg::OFF_DST_HI: next_rdata = {12'h000, dst[wch][19:16]};
        tcd_pkg::OFF_CNT:    next_rdata = cnt[wch];
        tcd_pkg::OFF_CTL:    next_rdata = ctl[wch];
        default:             next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      src   <= {tcd_pkg::NCH{tcd_pkg::PTR_RESET}};
      dst   <= {tcd_pkg::NCH{tcd_pkg::PTR_RESET}};
      cnt   <= {tcd_pkg::NCH{tcd_pkg::CNT_RESET}};
      ctl   <= {tcd_pkg::NCH{tcd_pkg::CTL_RESET}};
      state <= tcd_pkg::S_IDLE;
      bus   <= '0;
      cur   <= 1'b0;
      gap   <= '0;
      halt  <= 1'b0;
      irq   <= '0;
      rdata <= '0;
    end else begin
      src   <= next_src;
      dst   <= next_dst;
      cnt   <= next_cnt;
      ctl   <= next_ctl;
      state <= next_state;
      bus   <= next_bus;
      cur   <= next_cur;
      gap   <= next_gap;
      halt  <= next_halt;
      irq   <= next_irq;
      rdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // lock tells the bus arbiter to refuse hold/refresh across the pair
  assign O_BUS_LOCK = (state == tcd_pkg::S_READ) | (state == tcd_pkg::S_WRITE);
  assign O_BUS      = bus;
  assign O_IRQ      = irq;
  assign O_HALTED   = halt;
  assign O_RDATA    = rdata;

endmodule

// >>> tb/tcd_dma_unit_monitor.sv
`timescale 1ns/1ps
// --
// bus pairing, halt and interrupt checks
// --
module tcd_dma_unit_monitor (
  input wire logic              I_CLK,
  input wire logic              I_RST_N,
  input wire logic              I_NMI,
  input wire logic              I_IRET,
  input wire logic              I_BUS_DONE,
  input wire logic [15:0]       I_BUS_RDATA,
  input wire tcd_pkg::tcd_bus_s O_BUS,
  input wire logic              O_BUS_LOCK,
  input wire logic [1:0]        O_IRQ,
  input wire logic              O_HALTED
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);
  sequence s_rd_done;
    O_BUS.valid && !O_BUS.write && I_BUS_DONE;
  endsequence
  sequence s_wr_done;
    O_BUS.valid && O_BUS.write && I_BUS_DONE;
  endsequence
  a_pair_kept: assert property (s_rd_done |=> O_BUS.valid && O_BUS.write)
    else $error("read not followed by write");
  a_data_carry: assert property (s_rd_done |=> O_BUS.data == $past(I_BUS_RDATA))
    else $error("write data differs from read");
  a_pair_ends: assert property (s_wr_done |=> !O_BUS.valid)
    else $error("bus not released after write");
  a_lock_held: assert property (O_BUS.valid |-> O_BUS_LOCK)
    else $error("lock low during bus cycle");
  a_bus_stands: assert property (O_BUS.valid && !I_BUS_DONE |=> $stable(O_BUS))
    else $error("bus changed before done");
  a_halt_set: assert property (I_NMI |=> O_HALTED)
    else $error("halt not set");
  a_halt_clr: assert property (I_IRET && !I_NMI |=> !O_HALTED)
    else $error("halt not cleared");
  a_halt_block: assert property (O_HALTED && !O_BUS.valid |=> !O_BUS.valid)
    else $error("transfer started while halted");
  a_irq_cause: assert property (O_IRQ != 2'h0 |-> $past(I_BUS_DONE) && $past(O_BUS.write))
    else $error("interrupt without finished write");
  a_irq_pulse: assert property (O_IRQ != 2'h0 |=> O_IRQ == 2'h0)
    else $error("interrupt longer than one cycle");
endmodule

bind tcd_dma_unit tcd_dma_unit_monitor u_mon (
  .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_NMI(I_NMI), .I_IRET(I_IRET), .I_BUS_DONE(I_BUS_DONE),
  .I_BUS_RDATA(I_BUS_RDATA), .O_BUS(O_BUS), .O_BUS_LOCK(O_BUS_LOCK), .O_IRQ(O_IRQ),
  .O_HALTED(O_HALTED));

// >>> tb/tcd_bus_model.sv
`timescale 1ns/1ps
// --
// memory and i/o responder
// --
module tcd_bus_model (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire tcd_pkg::tcd_bus_s i_bus,
  input  wire logic [2:0]        i_wait,
  output logic                   o_done,
  output logic [15:0]            o_rdata
);
  logic [2:0]  cnt;
  logic [15:0] junk;
  assign o_done  = i_bus.valid && cnt == i_wait;
  // data only with done; otherwise a moving pattern so a late capture is caught
  assign o_rdata = o_done ? i_bus.addr[15:0] ^ {i_bus.addr[19:16], 11'h0, i_bus.mem_space}
                          : junk;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt  <= 3'h0;
      junk <= 16'h0;
    end else begin
      cnt  <= (o_done || !i_bus.valid) ? 3'h0 : cnt + 3'h1;
      junk <= junk + 16'h9e37;
    end
  end
endmodule

// >>> tb/tcd_dma_unit_bench.sv
`timescale 1ns/1ps
module tcd_dma_unit_bench;
  typedef struct packed {
    logic        mem;
    logic        word;
    logic [19:0] addr;
    logic [15:0] data;
  } tcd_exp_s;
  logic              clk, lock, done, halted;
  logic              rst_n = 0, wr = 0, rd = 0, tovf = 0, nmi = 0, iret = 0, rd_d = 0, v_d = 0;
  logic [7:0]        addr = 0;
  logic [15:0]       wdata = 0, rdata, brdata;
  logic [1:0]        pin = 0, ssel = 0, sreq = 0, irq;
  logic [2:0]        wt = 0;
  logic [19:0]       sa, da;
  logic [31:0]       r, lfsr = 32'h00012353;
  tcd_pkg::tcd_bus_s bus;
  tcd_exp_s          xq[$];
  logic [15:0]       rq[$];
  int                error_cnt = 0, n_checks = 0, irq_cnt = 0, exp_irq = 0, cyc = 0;
  // unsynchronized: one idle cycle, so the next read shows two edges after done
  int                last_wr = 0, gap_want = 2;

  tcd_dma_unit u_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_REQ_PIN(pin), .I_SERIAL_SEL(ssel), .I_SERIAL_REQ(sreq),
    .I_TIMER_OVF(tovf), .I_NMI(nmi), .I_IRET(iret), .O_BUS(bus), .O_BUS_LOCK(lock),
    .I_BUS_DONE(done), .I_BUS_RDATA(brdata), .O_IRQ(irq), .O_HALTED(halted));
  tcd_bus_model u_mem (.i_clk(clk), .i_rst_n(rst_n), .i_bus(bus), .i_wait(wt), .o_done(done),
    .o_rdata(brdata));

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // --
  // helpers
  // --
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic [19:0] step(input logic [19:0] p, input logic dn, up, w);
    if (dn ^ up)
      return dn ? p - (w ? 20'h2 : 20'h1) : p + (w ? 20'h2 : 20'h1);
    return p;
  endfunction
  task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t read %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_xfer(input tcd_exp_s g, input tcd_exp_s e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t write %h want %h", $time, g, e);
    end
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    rq.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic kick(input logic [2:0] m);
    {tovf, nmi, iret} <= m;
    @(posedge clk);
    {tovf, nmi, iret} <= 3'h0;
  endtask
  task automatic drain();
    for (int t = 0; t < 400 && xq.size() != 0; t++)
      @(posedge clk);
    repeat (4) @(posedge clk);
    chk_reg(16'(xq.size()), 16'h0);
  endtask
  // control is written last so the channel starts with its pointers in place
  task automatic setup(input logic [7:0] b, inout logic [19:0] s, d,
                       input logic [15:0] n, c);
    wreg(b, s[15:0]);
    wreg(b | 8'h2, {12'h0, s[19:16]});
    wreg(b | 8'h4, d[15:0]);
    wreg(b | 8'h6, {12'h0, d[19:16]});
    wreg(b | 8'h8, n);
    for (int k = 0; k < int'(n); k++) begin
      xq.push_back({c[15], c[0], d, s[15:0] ^ {s[19:16], 11'h0, c[12]}});
      s = step(s, c[11], c[10], c[0]);
      d = step(d, c[14], c[13], c[0]);
    end
    if (c[8] && c[9])
      exp_irq++;
    wreg(b | 8'ha, c);
  endtask
  task automatic run_rand(input logic [7:0] b, input logic [15:0] n);
    logic [15:0] c;
    r = rnd();
    c = (r[15:0] & 16'hff01) | 16'h0006;
    r = rnd();
    sa = c[12] ? r[19:0] : {4'h0, r[15:0]};
    r = rnd();
    da = c[15] ? r[19:0] : {4'h0, r[15:0]};
    setup(b, sa, da, n, c);
    drain();
    rreg(b | 8'h8, 16'h0);
    rreg(b | 8'ha, c & 16'hfff1);
    rreg(b, sa[15:0]);
    rreg(b | 8'h4, da[15:0]);
  endtask
  // --
  // result watcher
  // --
  always @(posedge clk) begin
    rd_d <= rd;
    irq_cnt <= irq_cnt + int'(irq[0]) + int'(irq[1]);
    if (rd_d)
      chk_reg(rdata, rq.pop_front());
    if (bus.valid && bus.write && done)
      chk_xfer({bus.mem_space, bus.word, bus.addr, bus.data}, xq.pop_front());
    // a read begun shortly after a write shows the idle time the mode asks for
    v_d <= bus.valid;
    if (bus.valid && bus.write && done)
      last_wr <= cyc;
    if (bus.valid && !v_d && cyc - last_wr < 8)
      chk_reg(16'(cyc - last_wr), 16'(gap_want));
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // --
  // scenarios
  // --
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rreg(8'hca, 16'h0);
    wreg(8'hcc, 16'hffff);
    rreg(8'hcc, 16'h0);
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      wt <= r[2:0];
      run_rand(i[0] ? 8'hd0 : 8'hc0, 16'(i % 3 + 1));
    end
    wreg(8'hda, 16'h00c6);
    pin <= 2'b10;
    wreg(8'hda, 16'h00c0);
    repeat (8) @(posedge clk);
    pin <= 2'b00;
    rreg(8'hda, 16'h00c2);
    rreg(8'hd8, 16'h0);
    wreg(8'hda, 16'h0004);
    rreg(8'hda, 16'h0);
    gap_want = 2 + int'(tcd_pkg::SRC_GAP_CYC);
    sa = 20'h1a000;
    da = 20'h2b000;
    setup(8'hd0, sa, da, 16'h1, 16'h9266);
    sa = 20'h1a100;
    setup(8'hc0, sa, da, 16'h1, 16'h9246);
    pin <= 2'b11;
    drain();
    pin <= 2'b00;
    ssel <= 2'b01;
    sa = 20'h0c000;
    setup(8'hc0, sa, da, 16'h2, 16'h9286);
    pin <= 2'b01;
    repeat (20) @(posedge clk);
    chk_reg(16'(xq.size()), 16'h2);
    gap_want = 2 + int'(tcd_pkg::DST_IDLE_CYC);
    sreq <= 2'b01;
    drain();
    {pin, sreq, ssel} <= 6'h0;
    sa = 20'h3c010;
    setup(8'hc0, sa, da, 16'h1, 16'h9386);
    kick(3'b100);
    repeat (20) @(posedge clk);
    chk_reg(16'(xq.size()), 16'h1);
    wreg(8'hca, 16'h9396);
    kick(3'b100);
    drain();
    kick(3'b010);
    sa = 20'h05555;
    setup(8'hc0, sa, da, 16'h1, 16'h9006);
    repeat (20) @(posedge clk);
    chk_reg(16'(xq.size()), 16'h1);
    kick(3'b001);
    drain();
    chk_reg(16'(irq_cnt), 16'(exp_irq));
    end_of_test();
  end
endmodule
